//--- src/cpu_exc_consts.vh
`ifndef CPU_EXC_CONSTS_VH
`define CPU_EXC_CONSTS_VH

// status word layout and reset value
`define SR_T_BIT 15
`define SR_MASK_LSB 8
`define SR_MASK_MSB 10
`define SR_RESET_VAL 16'h0700
`define MASK_ALL 3'h7

// least low time of the init pin, in system clock cycles
`define INIT_MIN_LOW_CYCLES 3'd6

// vector entry indices (minimum-mode byte address divided by two)
`define VEC_RESET 8'h00
`define VEC_INVALID 8'h02
`define VEC_ZERO_DIV 8'h03
`define VEC_OVF_TRAP 8'h04
`define VEC_ADDR_ERR 8'h08
`define VEC_TRACE 8'h09
`define VEC_TRAP_BASE 8'h10

// register field and external i/o area, no code may be fetched here
`define REG_FIELD_LO 16'hfe80
`define REG_FIELD_HI 16'hffff

// instruction exception kinds from the pipeline
`define EXC_INVALID 2'd0
`define EXC_ZERO_DIV 2'd1
`define EXC_OVF_TRAP 2'd2
`define EXC_VEC_TRAP 2'd3

// cause codes shown in the status view
`define CAUSE_NONE 3'd0
`define CAUSE_RESET 3'd1
`define CAUSE_ADDR_ERR 3'd2
`define CAUSE_INSTR 3'd3
`define CAUSE_TRACE 3'd4
`define CAUSE_IRQ 3'd5

// bus register offsets and responses
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_COUNT 8'h08
`define OFS_PCVIEW 8'h0c
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- src/cpu_exception_sequencer.v
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_exc_consts.vh"

module cpu_exception_sequencer #(
  parameter ADDR_W = 8
) (
  input wire clk,
  input wire rst_n,
  input wire chipInitPin_n,
  input wire instrDone,
  input wire [15:0] nextPc,
  input wire maskHoldInstr,
  input wire excReq,
  input wire [1:0] excKind,
  input wire [3:0] trapNum,
  input wire fetchValid,
  input wire [23:0] fetchAddr,
  input wire dataValid,
  input wire dataWord,
  input wire [23:0] dataAddr,
  input wire irqReq,
  input wire [2:0] irqLevel,
  input wire [7:0] irqVecIdx,
  output reg irqAck,
  input wire statusLoad,
  input wire [15:0] statusLoadData,
  output reg [15:0] statusWord,
  input wire [7:0] curCodeBank,
  input wire [15:0] stackTop,
  input wire [7:0] stackPage,
  output wire inReset,
  output wire seqBusy,
  output reg branchValid,
  output wire [15:0] branchPc,
  output wire [7:0] branchCodeBank,
  output reg stackLoad,
  output wire [15:0] stackTopNew,
  output reg memReq,
  output reg memWrite,
  output reg [23:0] memAddr,
  output reg [15:0] memWData,
  input wire [15:0] memRData,
  input wire memAck,
  input wire [ADDR_W-1:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [ADDR_W-1:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready
);

  localparam S_HOLD = 3'd0;
  localparam S_IDLE = 3'd1;
  localparam S_PUSH_PC = 3'd2;
  localparam S_PUSH_CP = 3'd3;
  localparam S_PUSH_SR = 3'd4;
  localparam S_VEC_HI = 3'd5;
  localparam S_VEC_PC = 3'd6;
  localparam S_DONE = 3'd7;

  reg [2:0] state_reg;
  reg pinMeta_reg;
  reg pinSync_reg;
  reg pinPrev_reg;
  reg [2:0] lowCount_reg;
  reg aePend_reg;
  reg irqBlock_reg;
  reg didPush_reg;
  reg [2:0] cause_reg;
  reg [7:0] vecIdx_reg;
  reg [15:0] srSave_reg;
  reg [7:0] cpSave_reg;
  reg [15:0] spWork_reg;
  reg [15:0] pcWork_reg;
  reg [7:0] cpWork_reg;
  reg [31:0] excCount_reg;
  reg maxMode_reg;
  reg awHeld_reg;
  reg wHeld_reg;
  reg [ADDR_W-1:0] awAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;

  wire addrFault;
  wire pinRise;
  wire atBoundary;
  wire chainPoint;
  wire aeAny;
  wire takeAe;
  wire takeExc;
  wire takeTrace;
  wire takeIrq;
  wire startSeq;
  wire [15:0] spBase;
  wire [15:0] savePc;
  wire [7:0] saveCp;
  wire [7:0] stackPageEff;
  wire [15:0] vecAddr;
  wire [15:0] spDown;
  wire awTake;
  wire wTake;
  wire doWrite;
  wire [ADDR_W-1:0] wrAddr;
  wire [31:0] wrData;
  wire [3:0] wrStrb;
  reg [7:0] startVec;
  reg [2:0] startCause;
  reg [7:0] excVec;

  exc_addr_check u_addr_check (
    .clk(clk),
    .rst_n(rst_n),
    .maxMode(maxMode_reg),
    .fetchValid(fetchValid),
    .fetchAddr(fetchAddr),
    .dataValid(dataValid),
    .dataWord(dataWord),
    .dataAddr(dataAddr),
    .addrFault(addrFault)
  );

  // init pin edge and outputs
  assign pinRise = pinSync_reg && !pinPrev_reg;
  assign inReset = (state_reg == S_HOLD);
  assign seqBusy = (state_reg != S_IDLE);
  assign branchPc = pcWork_reg;
  assign branchCodeBank = cpWork_reg;
  assign stackTopNew = spWork_reg;

  // exception arbitration at the instruction boundary
  assign atBoundary = (state_reg == S_IDLE) && instrDone;
  assign chainPoint = (state_reg == S_DONE);
  assign aeAny = aePend_reg || addrFault;
  assign takeAe = atBoundary && aeAny;
  assign takeExc = atBoundary && !aeAny && excReq;
  assign takeTrace = atBoundary && !aeAny && !excReq && statusWord[`SR_T_BIT];
  // reset block guards the chain point; a control load at a boundary defers one instruction
  assign takeIrq = irqReq &&
                   ((chainPoint && !irqBlock_reg) ||
                    (atBoundary && !maskHoldInstr && !aeAny && !excReq && !statusWord[`SR_T_BIT]));
  assign startSeq = takeAe || takeExc || takeTrace || takeIrq;

  // a chained interrupt stacks on top of the frame just built
  assign spBase = chainPoint ? spWork_reg : stackTop;
  assign savePc = chainPoint ? pcWork_reg : nextPc;
  assign saveCp = chainPoint ? cpWork_reg : curCodeBank;
  assign stackPageEff = maxMode_reg ? stackPage : 8'h00;
  assign spDown = spWork_reg - 16'h0002;

  // vector entry address: 2 bytes per entry, 4 in maximum mode
  assign vecAddr = maxMode_reg ? {6'h00, vecIdx_reg, 2'b00} : {7'h00, vecIdx_reg, 1'b0};

  // instruction exception vector
  always @* begin
    case (excKind)
      `EXC_INVALID: excVec = `VEC_INVALID;
      `EXC_ZERO_DIV: excVec = `VEC_ZERO_DIV;
      `EXC_OVF_TRAP: excVec = `VEC_OVF_TRAP;
      default: excVec = `VEC_TRAP_BASE + {4'h0, trapNum};
    endcase
  end

  // vector and cause for the winning exception
  always @* begin
    if (takeAe) begin
      startVec = `VEC_ADDR_ERR;
      startCause = `CAUSE_ADDR_ERR;
    end else if (takeExc) begin
      startVec = excVec;
      startCause = `CAUSE_INSTR;
    end else if (takeTrace) begin
      startVec = `VEC_TRACE;
      startCause = `CAUSE_TRACE;
    end else begin
      startVec = irqVecIdx;
      startCause = `CAUSE_IRQ;
    end
  end

  // init pin synchroniser; logic reset counts as a long power-up low
  always @(posedge clk) begin
    if (!rst_n) begin
      pinMeta_reg <= 1'b0;
      pinSync_reg <= 1'b0;
      pinPrev_reg <= 1'b0;
    end else begin
      pinMeta_reg <= chipInitPin_n;
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg;
    end
  end

  // exception sequencer
  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= S_HOLD;
      lowCount_reg <= `INIT_MIN_LOW_CYCLES;
      statusWord <= `SR_RESET_VAL;
      aePend_reg <= 1'b0;
      irqBlock_reg <= 1'b1;
      didPush_reg <= 1'b0;
      cause_reg <= `CAUSE_NONE;
      vecIdx_reg <= 8'h00;
      srSave_reg <= 16'h0000;
      cpSave_reg <= 8'h00;
      spWork_reg <= 16'h0000;
      pcWork_reg <= 16'h0000;
      cpWork_reg <= 8'h00;
      excCount_reg <= 32'h00000000;
      memReq <= 1'b0;
      memWrite <= 1'b0;
      memAddr <= 24'h000000;
      memWData <= 16'h0000;
      irqAck <= 1'b0;
      branchValid <= 1'b0;
      stackLoad <= 1'b0;
    end else if (!pinSync_reg) begin
      // pin low: stop and hold initial state
      state_reg <= S_HOLD;
      if (lowCount_reg != `INIT_MIN_LOW_CYCLES) begin
        lowCount_reg <= lowCount_reg + 3'd1;
      end
      statusWord <= `SR_RESET_VAL;
      aePend_reg <= 1'b0;
      irqBlock_reg <= 1'b1;
      memReq <= 1'b0;
      memWrite <= 1'b0;
      irqAck <= 1'b0;
      branchValid <= 1'b0;
      stackLoad <= 1'b0;
    end else begin
      lowCount_reg <= 3'd0;
      irqAck <= 1'b0;
      branchValid <= 1'b0;
      stackLoad <= 1'b0;
      // a fault arriving with its own service is consumed by it
      aePend_reg <= takeAe ? 1'b0 : (aePend_reg || addrFault);
      if (state_reg == S_IDLE && statusLoad) begin
        statusWord <= statusLoadData;
      end
      if (atBoundary) begin
        irqBlock_reg <= maskHoldInstr;
      end
      case (state_reg)
        S_HOLD: begin
          if (pinRise && lowCount_reg == `INIT_MIN_LOW_CYCLES) begin
            statusWord[`SR_T_BIT] <= 1'b0;
            statusWord[`SR_MASK_MSB:`SR_MASK_LSB] <= `MASK_ALL;
            irqBlock_reg <= 1'b1;
            didPush_reg <= 1'b0;
            cause_reg <= `CAUSE_RESET;
            vecIdx_reg <= `VEC_RESET;
            cpWork_reg <= curCodeBank;
            memReq <= 1'b1;
            memWrite <= 1'b0;
            memAddr <= 24'h000000;
            state_reg <= maxMode_reg ? S_VEC_HI : S_VEC_PC;
            excCount_reg <= excCount_reg + 32'h00000001;
          end
        end
        S_PUSH_PC: begin
          if (memAck) begin
            spWork_reg <= spDown;
            memAddr <= {stackPageEff, spDown};
            memWData <= maxMode_reg ? {8'h00, cpSave_reg} : srSave_reg;
            state_reg <= maxMode_reg ? S_PUSH_CP : S_PUSH_SR;
          end
        end
        S_PUSH_CP: begin
          if (memAck) begin
            spWork_reg <= spDown;
            memAddr <= {stackPageEff, spDown};
            memWData <= srSave_reg;
            state_reg <= S_PUSH_SR;
          end
        end
        S_PUSH_SR: begin
          if (memAck) begin
            memWrite <= 1'b0;
            memAddr <= {8'h00, vecAddr};
            state_reg <= maxMode_reg ? S_VEC_HI : S_VEC_PC;
          end
        end
        S_VEC_HI: begin
          if (memAck) begin
            cpWork_reg <= memRData[7:0];
            memAddr <= {8'h00, vecAddr + 16'h0002};
            state_reg <= S_VEC_PC;
          end
        end
        S_VEC_PC: begin
          if (memAck) begin
            pcWork_reg <= memRData;
            memReq <= 1'b0;
            branchValid <= 1'b1;
            stackLoad <= didPush_reg;
            state_reg <= S_DONE;
          end
        end
        default: begin
          // idle, or end of a sequence where a waiting interrupt may chain in
          if (startSeq) begin
            srSave_reg <= statusWord;
            statusWord[`SR_T_BIT] <= 1'b0;
            if (takeIrq) begin
              statusWord[`SR_MASK_MSB:`SR_MASK_LSB] <= irqLevel;
            end
            irqAck <= takeIrq;
            cpSave_reg <= saveCp;
            didPush_reg <= 1'b1;
            cause_reg <= startCause;
            vecIdx_reg <= startVec;
            spWork_reg <= spBase - 16'h0002;
            memReq <= 1'b1;
            memWrite <= 1'b1;
            memAddr <= {stackPageEff, spBase - 16'h0002};
            memWData <= savePc;
            state_reg <= S_PUSH_PC;
            excCount_reg <= excCount_reg + 32'h00000001;
          end else begin
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  // bus write side: address and data taken in either order
  assign awready = !awHeld_reg && !bvalid;
  assign wready = !wHeld_reg && !bvalid;
  assign awTake = awvalid && awready;
  assign wTake = wvalid && wready;
  assign doWrite = (awHeld_reg || awTake) && (wHeld_reg || wTake);
  assign wrAddr = awHeld_reg ? awAddr_reg : awaddr;
  assign wrData = wHeld_reg ? wData_reg : wdata;
  assign wrStrb = wHeld_reg ? wStrb_reg : wstrb;

  always @(posedge clk) begin
    if (!rst_n) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= {ADDR_W{1'b0}};
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      maxMode_reg <= 1'b0;
    end else begin
      if (awTake) begin
        awAddr_reg <= awaddr;
      end
      if (wTake) begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bvalid <= 1'b1;
        if (wrAddr == `OFS_CTRL) begin
          bresp <= `RESP_OKAY;
          if (wrStrb[0]) begin
            maxMode_reg <= wrData[0];
          end
        end else if (wrAddr == `OFS_STAT || wrAddr == `OFS_COUNT || wrAddr == `OFS_PCVIEW) begin
          bresp <= `RESP_OKAY;
        end else begin
          bresp <= `RESP_SLVERR;
        end
      end else begin
        if (awTake) begin
          awHeld_reg <= 1'b1;
        end
        if (wTake) begin
          wHeld_reg <= 1'b1;
        end
        if (bvalid && bready) begin
          bvalid <= 1'b0;
        end
      end
    end
  end

  // bus read side
  assign arready = !rvalid;

  always @(posedge clk) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `RESP_OKAY;
      if (araddr == `OFS_CTRL) begin
        rdata <= {31'h00000000, maxMode_reg};
      end else if (araddr == `OFS_STAT) begin
        rdata <= {statusWord, 6'h00, aePend_reg, irqBlock_reg, 1'b0, cause_reg, 1'b0, state_reg};
      end else if (araddr == `OFS_COUNT) begin
        rdata <= excCount_reg;
      end else if (araddr == `OFS_PCVIEW) begin
        rdata <= {8'h00, cpWork_reg, pcWork_reg};
      end else begin
        rdata <= 32'h00000000;
        rresp <= `RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- src/exc_addr_check.v
`timescale 1ns/1ps
`default_nettype none
`include "cpu_exc_consts.vh"

module exc_addr_check (
  input wire clk,
  input wire rst_n,
  input wire maxMode,
  input wire fetchValid,
  input wire [23:0] fetchAddr,
  input wire dataValid,
  input wire dataWord,
  input wire [23:0] dataAddr,
  output reg addrFault
);

  wire pageZero;
  wire fetchBad;
  wire dataBad;

  // register field lives in page 0 only; minimum mode has no pages
  assign pageZero = !maxMode || (fetchAddr[23:16] == 8'h00);
  assign fetchBad = fetchValid && pageZero &&
                    (fetchAddr[15:0] >= `REG_FIELD_LO) &&
                    (fetchAddr[15:0] <= `REG_FIELD_HI);
  assign dataBad = dataValid && dataWord && dataAddr[0];

  // fault flag, registered, high one cycle after each cycle with a bad access
  always @(posedge clk) begin
    if (!rst_n) begin
      addrFault <= 1'b0;
    end else begin
      addrFault <= fetchBad || dataBad;
    end
  end

endmodule
`default_nettype wire

//--- tb/exc_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module exc_seq_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instrDone,
  input wire logic maskHoldInstr,
  input wire logic irqAck,
  input wire logic [2:0] irqLevel,
  input wire logic [15:0] statusWord,
  input wire logic inReset,
  input wire logic seqBusy,
  input wire logic branchValid,
  input wire logic stackLoad,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic memAck,
  input wire logic [23:0] memAddr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // hold state and reset sequence
  a_init_status: assert property (inReset |-> statusWord == 16'h0700)
    else $error("status word not at init value while held");
  a_reset_fetch: assert property ($fell(inReset) |-> ##[0:1] (memReq && !memWrite && memAddr == 24'h0))
    else $error("reset vector fetch not from entry zero");
  a_reset_nopush: assert property ($fell(inReset) |-> (!(memReq && memWrite)) [*4])
    else $error("write seen during reset sequence");
  // exception entry
  a_irq_mask: assert property (irqAck |-> statusWord[10:8] == $past(irqLevel) && !statusWord[15])
    else $error("mask level not taken from accepted interrupt");
  a_t_clear: assert property ($rose(seqBusy) |-> !statusWord[15])
    else $error("single-step flag live during sequence");
  a_irq_hold: assert property (irqAck |-> !$past(maskHoldInstr))
    else $error("interrupt taken after control load");
  a_branch_pulse: assert property (branchValid |=> !branchValid)
    else $error("branch strobe longer than one cycle");
  a_mem_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWrite))
    else $error("memory request changed before ack");

  c_irq: cover property (irqAck);
  c_push: cover property (stackLoad);
  c_reset: cover property ($fell(inReset));
endmodule
bind cpu_exception_sequencer exc_seq_properties chk (.*);
`default_nettype wire

//--- tb/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [23:0] memAddr,
  input wire logic [15:0] memWData,
  output logic [15:0] memRData,
  output logic memAck
);
  logic [15:0] mem [0:255];
  int wt;
  // one ack per request, wait states when slow, read data scrambled off the ack
  always @(posedge clk) begin
    if (!rst_n) begin
      memAck <= 0;
      memRData <= 16'h0;
      wt = 0;
    end else if (memAck || !memReq) begin
      memAck <= 0;
      memRData <= ~memRData;
    end else if (wt > 0) begin
      wt--;
    end else begin
      memAck <= 1;
      wt = slow ? 2 : 0;
      if (memWrite) mem[memAddr[8:1]] <= memWData;
      else memRData <= mem[memAddr[8:1]];
    end
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst_n, chipInitPin_n, instrDone, maskHoldInstr, excReq, fetchValid, dataValid, dataWord;
  logic irqReq, statusLoad, irqAck, inReset, seqBusy, branchValid, stackLoad, memReq, memWrite, memAck;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, slow, mx;
  logic [1:0] excKind, bresp, rresp, rs;
  logic [2:0] irqLevel;
  logic [3:0] trapNum, wstrb, tn;
  logic [7:0] irqVecIdx, branchCodeBank, awaddr, araddr, idx;
  logic [15:0] nextPc, statusLoadData, statusWord, branchPc, stackTopNew, memWData, memRData, pc, sr, vw0, vw1;
  logic [23:0] fetchAddr, dataAddr, memAddr;
  logic [31:0] wdata, rdata, rd;
  int err_total = 0, checks_done = 0, irqCnt = 0, stkCnt = 0, expCnt = 0;

  cpu_exception_sequencer uut (.*, .curCodeBank(8'h5a), .stackTop(16'h0200), .stackPage(8'h00));
  mem_model m (.*);

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // count strobes, drop the request once accepted
  always @(posedge clk) begin
    irqCnt += irqAck;
    stkCnt += stackLoad;
    if (irqAck) irqReq <= 0;
  end

  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task tmo;
    err_total++;
    $display("unexpected at %0t: wait ran out", $time);
    test_done;
  endtask
  // returns at the falling edge where the branch strobe is seen
  task waitBr;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!branchValid && n < 300);
    if (!branchValid) tmo;
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w, b;
    aw = 1; w = 1; b = 0; n = 0;
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!b && n < 100) begin
      @(negedge clk);
      n++;
      b = bvalid; rs = bresp;
      if (awready) aw = 0;
      if (wready) w = 0;
      @(posedge clk);
      awvalid <= aw; wvalid <= w; bready <= !b;
    end
    if (!b) tmo;
  endtask
  task axr(input logic [7:0] a);
    int n;
    logic ar, r;
    ar = 1; r = 0; n = 0;
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!r && n < 100) begin
      @(negedge clk);
      n++;
      r = rvalid; rd = rdata; rs = rresp;
      if (arready) ar = 0;
      @(posedge clk);
      arvalid <= ar; rready <= !r;
    end
    if (!r) tmo;
  endtask
  // load the status word, then one instruction boundary
  task bnd(input logic ex, input logic [1:0] k, input logic mh);
    @(posedge clk);
    statusLoad <= 1; statusLoadData <= sr;
    @(posedge clk);
    statusLoad <= 0; instrDone <= 1; nextPc <= pc; excReq <= ex; excKind <= k; maskHoldInstr <= mh;
    @(posedge clk);
    instrDone <= 0; excReq <= 0; maskHoldInstr <= 0;
  endtask
  task go(input logic [7:0] v, input logic ex, input logic [1:0] k, input logic irq);
    pc = 16'($urandom); vw0 = 16'($urandom); vw1 = 16'($urandom);
    for (int i = 253; i < 256; i++) m.mem[i] = 16'hffff;
    if (mx) begin
      m.mem[v * 2] = vw0;
      m.mem[v * 2 + 1] = vw1;
    end else m.mem[v] = vw1;
    bnd(ex, k, 1'b0);
    waitBr;
    chk(branchPc, vw1);
    chk(statusWord, irq ? {1'b0, sr[14:11], irqLevel, sr[7:0]} : {1'b0, sr[14:0]});
    chk(m.mem[255], pc);
    chk(m.mem[mx ? 253 : 254], sr);
    chk(stackTopNew, mx ? 16'h01fa : 16'h01fc);
    if (mx) chk({m.mem[254], branchCodeBank}, {16'h005a, vw0[7:0]});
    chk({stackLoad, seqBusy}, 2'b11);
    expCnt++;
    @(posedge clk);
    $display("exception entry %h done", v);
  endtask
  task rstv(input logic pin);
    vw0 = 16'($urandom); vw1 = 16'($urandom); stkCnt = 0;
    if (mx) begin
      m.mem[0] = vw0;
      m.mem[1] = vw1;
    end else m.mem[0] = vw1;
    if (pin) begin
      chipInitPin_n <= 0;
      repeat (3) @(posedge clk);
      chipInitPin_n <= 1;
      repeat (6) @(posedge clk);
      chipInitPin_n <= 0;
      @(negedge clk) chk(inReset, 1'b1);
      repeat (10) @(posedge clk);
      @(negedge clk) chk(inReset, 1'b1);
      @(posedge clk) chipInitPin_n <= 1;
    end
    waitBr;
    chk(branchPc, vw1);
    chk(statusWord, 16'h0700);
    chk(stkCnt, 0);
    if (mx) chk(branchCodeBank, vw0[7:0]);
    expCnt++;
    @(posedge clk);
    $display("reset sequence done");
  endtask

  initial begin
    void'($urandom(77123));
    {rst_n, instrDone, maskHoldInstr, excReq, fetchValid, dataValid, dataWord, irqReq, statusLoad} = '0;
    {awvalid, wvalid, bready, arvalid, rready, slow, mx, excKind, trapNum, wstrb, irqLevel} = '0;
    {nextPc, statusLoadData, fetchAddr, dataAddr, irqVecIdx, awaddr, araddr, wdata} = '0;
    chipInitPin_n = 1;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    rstv(1'b0);
    // interrupt held off across a control load boundary
    irqLevel <= 3'd5; irqVecIdx <= 8'h0b; irqReq <= 1; sr = 16'h0200; pc = 16'h0100;
    bnd(1'b0, 2'd0, 1'b1);
    repeat (8) @(posedge clk);
    chk(irqCnt, 0);
    for (int md = 0; md < 2; md++) begin
      if (md == 1) begin
        axw(8'h00, 32'h1); chk(rs, 2'b00);
        axr(8'h00); chk({rs, rd}, {2'b00, 32'h1});
        axr(8'h40); chk({rs, rd}, {2'b10, 32'h0});
        axw(8'h44, 32'h1); chk(rs, 2'b10);
        mx = 1; slow <= 1;
        irqLevel <= 3'd2; irqVecIdx <= 8'h20; irqReq <= 1;
        @(posedge clk);
      end
      sr = 16'($urandom) & 16'h7fff;
      go(irqVecIdx, 1'b0, 2'd0, 1'b1);
      for (int k = 0; k < 4; k++) begin
        tn = 4'($urandom); trapNum <= tn; sr = 16'($urandom) & 16'h7fff;
        idx = (k == 3) ? 8'h10 + {4'h0, tn} : 8'(2 + k);
        go(idx, 1'b1, 2'(k), 1'b0);
      end
      sr = 16'($urandom) | 16'h8000;
      go(8'h09, 1'b0, 2'd0, 1'b0);
      @(posedge clk) begin dataValid <= 1; dataWord <= 1; dataAddr <= 24'h000101; end
      @(posedge clk) dataValid <= 0;
      go(8'h08, 1'b0, 2'd0, 1'b0);
      @(posedge clk) begin fetchValid <= 1; fetchAddr <= 24'h00fe80; end
      @(posedge clk) fetchValid <= 0;
      sr = 16'($urandom) & 16'h7fff;
      go(8'h08, 1'b0, 2'd0, 1'b0);
    end
    // exception count, branch view and status view after the last address error
    axr(8'h08);
    chk({rs, rd}, {2'b00, 32'(expCnt)});
    axr(8'h0c);
    chk({rs, rd}, {2'b00, 8'h00, vw0[7:0], vw1});
    axr(8'h04);
    chk({rs, rd}, {2'b00, 1'b0, sr[14:0], 16'h0021});
    rstv(1'b1);
    test_done;
  end
endmodule
`default_nettype wire
